// >>> pkg/scs_pkg.sv
// shared constants and types for the scan-cycle sequencer
package scs_pkg;
    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned WDOG_DEFAULT_MS = 200;
    localparam int unsigned WDOG_DEFAULT_CYC = WDOG_DEFAULT_MS * 1000 * CLK_MHZ;
    localparam logic [15:0] ERR_SW_TIMEOUT = 16'h0003;
    localparam int unsigned NUM_LOOPS = 8;
    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_INPUT_IMG = 8'h08;
    localparam logic [7:0] REG_OUTPUT_IMG = 8'h0c;
    localparam logic [7:0] REG_OVERRIDE_X = 8'h10;
    localparam logic [7:0] REG_OVERRIDE_Y = 8'h14;
    localparam logic [7:0] REG_FORCE = 8'h18;
    localparam logic [7:0] REG_WDOG = 8'h1c;
    localparam logic [7:0] REG_SCAN_CUR = 8'h20;
    localparam logic [7:0] REG_SCAN_MIN = 8'h24;
    localparam logic [7:0] REG_SCAN_MAX = 8'h28;
    localparam logic [7:0] REG_LOOP_CFG = 8'h2c;
    localparam logic [7:0] REG_LOOP_IVL = 8'h30;
    localparam logic [7:0] REG_ERROR = 8'h34;
    localparam logic [7:0] REG_CLOCK = 8'h38;
    localparam logic [7:0] REG_SPECIAL = 8'h3c;
    // ctrl fields
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_ERRCLR_BIT = 1;
    // force fields: [4:0] point, [5] value, [6] 1=output image, [7] go
    localparam int FORCE_VAL_BIT = 5;
    localparam int FORCE_SEL_BIT = 6;
    localparam int FORCE_GO_BIT = 7;
    localparam logic [31:0] SCAN_MIN_RESET = 32'hffffffff;
    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [3:0] {
        SCS_IN_READ = 4'b0000,
        SCS_PERIPH = 4'b0001,
        SCS_BUS = 4'b0010,
        SCS_CLOCK = 4'b0011,
        SCS_SOLVE = 4'b0100,
        SCS_LOOPS = 4'b0101,
        SCS_OUT_WRITE = 4'b0110,
        SCS_SPECIALTY = 4'b0111,
        SCS_DIAG = 4'b1000
    } scs_phase_e;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } scs_apb_req_s;
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } scs_apb_rsp_s;
    typedef struct packed {
        logic req;
        logic we;
        logic [31:0] wdata;
    } scs_lbus_req_s;
endpackage

// >>> rtl/scs_loop_sched.sv
// loop calculation scheduler: one interval counter per configured loop
module scs_loop_sched
    import scs_pkg::*;
#(
    parameter int N = NUM_LOOPS,
    parameter int W = 16
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // control
    input wire logic i_tick,
    input wire logic [N-1:0] i_enable,
    input wire logic [W-1:0] i_interval,
    // result
    output logic [N-1:0] o_due,
    output logic [N-1:0] o_done
);
    typedef struct packed {
        logic [N-1:0][W-1:0] cnt;
        logic [N-1:0] due;
        logic [N-1:0] done;
    } scs_sched_s;
    scs_sched_s st, next_st;

    // ************************************************************
    // per-loop interval counters
    // ************************************************************
    always_comb begin
        next_st = st;
        for (int k = 0; k < N; k++) begin
            next_st.due[k] = 1'b0;
            if (i_tick) begin
                next_st.done[k] = 1'b0;
                if (!i_enable[k]) begin
                    next_st.cnt[k] = '0;
                end else if (st.cnt[k] >= i_interval) begin
                    next_st.cnt[k] = '0;
                    next_st.due[k] = 1'b1; // RQ11
                    next_st.done[k] = 1'b1;
                end else begin
                    next_st.cnt[k] = st.cnt[k] + W'(1);
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_due = st.due;
    assign o_done = st.done;
endmodule

// >>> rtl/scs_top.sv
// scan-cycle sequencer with image, override, force and watchdog
// What this block does
// (RQ1) after input read, serve peripheral requests to change bits
// (RQ2) regular force lasts until that image bit is next written
// (RQ3) per-point override flag freezes discrete image bits
// (RQ4) overridden points ignore all internal changes, including physical input
// (RQ5) peripheral force still works on overridden points and sticks
// (RQ6) program results and i/o update never touch overridden bits
// (RQ7) dedicated bus phase performs local base reads and writes
// (RQ8) clock/calendar and special relays refreshed every scan
// (RQ9) program solve writes output image, not physical outputs
// (RQ10) immediate output drives the physical pin at once
// (RQ11) up to 8 configured loops run after solve, all on one shared interval (loop_ivl)
// (RQ12) output write copies full output image, forces included
// (RQ13) specialty modules get output data after outputs update
// (RQ14) diagnostics check, compute scan time, restart watchdog
// (RQ15) solve past watchdog limit: program mode, outputs off, error
// (RQ16) overrun reports software timeout error code
// (RQ17) keep min, max, current scan time; watchdog limit settable
// (RQ18) input read just before read phase reaches output in one scan
// (RQ19) input missed by read phase is taken next scan
// (RQ20) inputs read in every mode; outputs driven only in run mode
// (RQ21) non-fatal errors keep mode; fatal forces program, outputs off
// (RQ22) phases run in a fixed repeating order
module scs_top
    import scs_pkg::*;
#(
    parameter int NPTS = 32,
    parameter logic [31:0] WDOG_CYC = 32'(WDOG_DEFAULT_CYC)
) (
    // clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    // apb slave
    input wire scs_pkg::scs_apb_req_s I_APB,
    output scs_pkg::scs_apb_rsp_s O_APB,
    // field i/o
    input wire logic [NPTS-1:0] I_FIELD_IN,
    output logic [NPTS-1:0] O_FIELD_OUT,
    // program engine
    input wire logic [NPTS-1:0] I_PROG_RESULT,
    input wire logic I_PROG_DONE,
    input wire logic I_IMM_OUT_VALID,
    input wire logic [4:0] I_IMM_OUT_PT,
    input wire logic I_IMM_OUT_VAL,
    output logic O_SOLVE_START,
    output logic [NPTS-1:0] O_INPUT_IMAGE,
    // local base bus, specialty and loops
    output scs_pkg::scs_lbus_req_s O_LBUS,
    input wire logic I_LBUS_DONE,
    input wire logic [31:0] I_LBUS_RDATA,
    output logic O_SPEC_VALID,
    output logic [NPTS-1:0] O_SPEC_DATA,
    output logic [NUM_LOOPS-1:0] O_LOOP_DUE,
    // status
    output scs_pkg::scs_phase_e O_PHASE,
    output logic O_RUN,
    output logic O_FATAL
);
    import scs_pkg::*;

    typedef struct packed {
        scs_phase_e phase;
        logic run;
        logic fatal;
        logic [15:0] err_code;
        logic [NPTS-1:0] x_img;
        logic [NPTS-1:0] y_img;
        logic [NPTS-1:0] ovr_x;
        logic [NPTS-1:0] ovr_y;
        logic [NPTS-1:0] out_pins;
        logic [7:0] force_cmd;
        logic [31:0] wdog_lim;
        logic [31:0] wdog_cnt;
        logic [31:0] scan_cnt;
        logic [31:0] scan_cur;
        logic [31:0] scan_min;
        logic [31:0] scan_max;
        logic [31:0] rtc;
        logic [31:0] special;
        logic [31:0] lbus_wdata;
        logic [31:0] lbus_rdata;
        logic [NUM_LOOPS-1:0] loop_en;
        logic [15:0] loop_ivl;
        logic [31:0] prdata;
        logic solve_start;
        logic spec_valid;
        logic [NPTS-1:0] spec_data;
    } scs_state_s;
    scs_state_s st, next_st;

    logic [NPTS-1:0] in_meta, in_sync;
    logic apb_wr, apb_rd, sched_tick;
    logic [NUM_LOOPS-1:0] loop_due, loop_done;

    function automatic logic [NPTS-1:0] merge_img(input logic [NPTS-1:0] old_v,
                                                   input logic [NPTS-1:0] new_v,
                                                   input logic [NPTS-1:0] frozen);
        merge_img = (old_v & frozen) | (new_v & ~frozen);
    endfunction

    // ************************************************************
    // field input synchroniser
    // ************************************************************
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            in_meta <= '0;
            in_sync <= '0;
        end else begin
            in_meta <= I_FIELD_IN;
            in_sync <= in_meta;
        end
    end

    // ************************************************************
    // apb decode, zero wait states
    // ************************************************************
    assign apb_wr = I_APB.psel & I_APB.penable & I_APB.pwrite;
    assign apb_rd = I_APB.psel & ~I_APB.pwrite;

    // ************************************************************
    // loop scheduler
    // ************************************************************
    assign sched_tick = (st.phase == SCS_LOOPS) && st.run;

    scs_loop_sched #(
        .N(NUM_LOOPS),
        .W(16)
    ) u_sched (
        .i_clk(I_CLOCK),
        .i_rst_n(I_RST_N),
        .i_tick(sched_tick),
        .i_enable(st.loop_en),
        .i_interval(st.loop_ivl),
        .o_due(loop_due),
        .o_done(loop_done)
    );

    // ************************************************************
    // scan sequencer
    // ************************************************************
    always_comb begin
        next_st = st;
        next_st.solve_start = 1'b0;
        next_st.spec_valid = 1'b0;
        next_st.scan_cnt = st.scan_cnt + 32'h1;
        unique case (st.phase)
            SCS_IN_READ: begin
                // always read, even in program mode
                next_st.x_img = merge_img(st.x_img, in_sync, st.ovr_x); // RQ4 RQ20 RQ18 RQ19
                next_st.phase = SCS_PERIPH; // RQ22
            end
            SCS_PERIPH: begin
                if (st.force_cmd[FORCE_GO_BIT]) begin // RQ1
                    // forcing bypasses the override mask on purpose
                    if (st.force_cmd[FORCE_SEL_BIT]) begin
                        next_st.y_img[st.force_cmd[4:0]] = st.force_cmd[FORCE_VAL_BIT]; // RQ2 RQ5
                    end else begin
                        next_st.x_img[st.force_cmd[4:0]] = st.force_cmd[FORCE_VAL_BIT]; // RQ2 RQ5
                    end
                    next_st.force_cmd[FORCE_GO_BIT] = 1'b0;
                end
                next_st.phase = SCS_BUS;
            end
            SCS_BUS: begin
                // stall until the local base module completes
                if (I_LBUS_DONE) begin
                    next_st.lbus_rdata = I_LBUS_RDATA; // RQ7
                    next_st.phase = SCS_CLOCK;
                end
            end
            SCS_CLOCK: begin
                next_st.rtc = st.rtc + 32'h1; // RQ8
                next_st.special = {st.run, st.fatal, 14'h0, st.err_code}; // RQ8
                next_st.phase = st.run ? SCS_SOLVE : SCS_DIAG;
                next_st.solve_start = st.run;
                next_st.wdog_cnt = '0;
            end
            SCS_SOLVE: begin
                next_st.wdog_cnt = st.wdog_cnt + 32'h1;
                if (I_PROG_DONE) begin
                    next_st.y_img = merge_img(st.y_img, I_PROG_RESULT, st.ovr_y); // RQ9 RQ6
                    next_st.phase = SCS_LOOPS;
                end else if (st.wdog_cnt >= st.wdog_lim) begin
                    next_st.run = 1'b0; // RQ15 RQ21
                    next_st.fatal = 1'b1;
                    next_st.err_code = ERR_SW_TIMEOUT; // RQ16
                    next_st.phase = SCS_OUT_WRITE;
                end
                if (I_IMM_OUT_VALID && !st.ovr_y[I_IMM_OUT_PT]) begin
                    next_st.out_pins[I_IMM_OUT_PT] = I_IMM_OUT_VAL; // RQ10
                end
            end
            SCS_LOOPS: begin
                next_st.phase = SCS_OUT_WRITE; // RQ11
            end
            SCS_OUT_WRITE: begin
                next_st.out_pins = st.run ? st.y_img : '0; // RQ12 RQ20 RQ21
                next_st.phase = SCS_SPECIALTY;
            end
            SCS_SPECIALTY: begin
                next_st.spec_valid = st.run; // RQ13
                next_st.spec_data = st.y_img;
                next_st.phase = SCS_DIAG;
            end
            SCS_DIAG: begin
                next_st.scan_cur = st.scan_cnt; // RQ14 RQ17
                if (st.scan_cnt < st.scan_min) next_st.scan_min = st.scan_cnt;
                if (st.scan_cnt > st.scan_max) next_st.scan_max = st.scan_cnt;
                next_st.scan_cnt = '0;
                next_st.wdog_cnt = '0; // RQ14
                next_st.phase = SCS_IN_READ;
            end
            default: next_st.phase = SCS_IN_READ;
        endcase

        // software writes; force go is cleared when serviced or by a force write with go low
        if (apb_wr) begin
            unique case (I_APB.paddr)
                REG_CTRL: begin
                    if (!st.fatal) next_st.run = I_APB.pwdata[CTRL_RUN_BIT];
                    if (I_APB.pwdata[CTRL_ERRCLR_BIT]) begin
                        next_st.fatal = 1'b0;
                        next_st.err_code = '0;
                    end
                    if (I_APB.pwdata[CTRL_RUN_BIT] && !st.run && !st.fatal) begin
                        next_st.scan_min = SCAN_MIN_RESET;
                        next_st.scan_max = '0;
                    end
                end
                REG_OVERRIDE_X: next_st.ovr_x = I_APB.pwdata[NPTS-1:0]; // RQ3
                REG_OVERRIDE_Y: next_st.ovr_y = I_APB.pwdata[NPTS-1:0]; // RQ3
                REG_FORCE: next_st.force_cmd = I_APB.pwdata[7:0];
                REG_WDOG: next_st.wdog_lim = I_APB.pwdata; // RQ17
                REG_LOOP_CFG: next_st.loop_en = I_APB.pwdata[NUM_LOOPS-1:0];
                REG_LOOP_IVL: next_st.loop_ivl = I_APB.pwdata[15:0];
                REG_SPECIAL: next_st.lbus_wdata = I_APB.pwdata;
                default: next_st.run = next_st.run;
            endcase
        end

        // read mux, registered in setup phase
        next_st.prdata = '0;
        if (apb_rd) begin
            unique case (I_APB.paddr)
                REG_CTRL: next_st.prdata = {30'h0, st.fatal, st.run};
                REG_STATUS: next_st.prdata = {20'h0, loop_done, st.phase};
                REG_INPUT_IMG: next_st.prdata = 32'(st.x_img);
                REG_OUTPUT_IMG: next_st.prdata = 32'(st.y_img);
                REG_OVERRIDE_X: next_st.prdata = 32'(st.ovr_x);
                REG_OVERRIDE_Y: next_st.prdata = 32'(st.ovr_y);
                REG_FORCE: next_st.prdata = {24'h0, st.force_cmd};
                REG_WDOG: next_st.prdata = st.wdog_lim;
                REG_SCAN_CUR: next_st.prdata = st.scan_cur;
                REG_SCAN_MIN: next_st.prdata = st.scan_min;
                REG_SCAN_MAX: next_st.prdata = st.scan_max;
                REG_LOOP_CFG: next_st.prdata = {24'h0, st.loop_en};
                REG_LOOP_IVL: next_st.prdata = {16'h0, st.loop_ivl};
                REG_ERROR: next_st.prdata = {16'h0, st.err_code};
                REG_CLOCK: next_st.prdata = st.rtc;
                REG_SPECIAL: next_st.prdata = st.lbus_rdata;
                default: next_st.prdata = '0;
            endcase
        end
        if (!next_st.run) next_st.out_pins = '0; // RQ20 RQ21
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            st <= '0;
            st.phase <= SCS_IN_READ;
            st.wdog_lim <= WDOG_CYC;
            st.scan_min <= SCAN_MIN_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign O_APB.pready = 1'b1;
    assign O_APB.pslverr = 1'b0;
    assign O_APB.prdata = st.prdata;
    assign O_FIELD_OUT = st.out_pins;
    assign O_SOLVE_START = st.solve_start;
    assign O_INPUT_IMAGE = st.x_img;
    assign O_LBUS.req = (st.phase == SCS_BUS);
    assign O_LBUS.we = 1'b1;
    assign O_LBUS.wdata = st.lbus_wdata;
    assign O_SPEC_VALID = st.spec_valid;
    assign O_SPEC_DATA = st.spec_data;
    assign O_LOOP_DUE = loop_due;
    assign O_PHASE = st.phase;
    assign O_RUN = st.run;
    assign O_FATAL = st.fatal;

    // ************************************************************
    // checks
    // ************************************************************
    property p_order;
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        (st.phase == SCS_IN_READ) |=> (st.phase == SCS_PERIPH);
    endproperty
    a_order: assert property (p_order) else $error("phase order broken"); // RQ22

    property p_prog_off;
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        !st.run |-> (O_FIELD_OUT == '0);
    endproperty
    a_prog_off: assert property (p_prog_off) else $error("outputs on in program"); // RQ20

    property p_wdog;
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        (st.phase == SCS_SOLVE && !I_PROG_DONE && st.wdog_cnt >= st.wdog_lim)
            |=> (!st.run && st.fatal && st.err_code == ERR_SW_TIMEOUT);
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog trip missed"); // RQ15

    property p_frozen_x;
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        (st.phase == SCS_IN_READ && st.ovr_x != '0)
            |=> (((st.x_img ^ $past(st.x_img)) & $past(st.ovr_x)) == '0);
    endproperty
    a_frozen_x: assert property (p_frozen_x) else $error("override input changed"); // RQ4

    property p_frozen_y;
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        (st.phase == SCS_SOLVE && I_PROG_DONE && st.ovr_y != '0)
            |=> (((st.y_img ^ $past(st.y_img)) & $past(st.ovr_y)) == '0);
    endproperty
    a_frozen_y: assert property (p_frozen_y) else $error("program wrote override"); // RQ6

    property p_outwrite;
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        (st.phase == SCS_OUT_WRITE && st.run) |=> (O_FIELD_OUT == $past(st.y_img) || !st.run);
    endproperty
    a_outwrite: assert property (p_outwrite) else $error("output copy wrong"); // RQ12

    property p_spec;
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        O_SPEC_VALID |-> ($past(st.phase) == SCS_SPECIALTY) && (O_SPEC_DATA == $past(st.y_img));
    endproperty
    a_spec: assert property (p_spec) else $error("specialty data wrong"); // RQ13

    property p_diag;
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        // a ctrl write that sets run from program mode in the same cycle restarts min/max and wins over the update
        (st.phase == SCS_DIAG && !(apb_wr && I_APB.paddr == REG_CTRL))
            |=> (st.scan_cur == $past(st.scan_cnt)) && (st.wdog_cnt == '0)
            && (st.scan_min <= st.scan_cur) && (st.scan_max >= st.scan_cur);
    endproperty
    a_diag: assert property (p_diag) else $error("scan stats wrong"); // RQ14

    property p_clock;
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        (st.phase == SCS_CLOCK) |=> (st.rtc == $past(st.rtc) + 32'h1);
    endproperty
    a_clock: assert property (p_clock) else $error("clock not refreshed"); // RQ8
endmodule

// >>> bench/scs_partner.sv
// far-side model: program engine and local base module answers
module scs_partner
    import scs_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // requests from the sequencer; solve delay from the bench
    input wire logic i_solve_start,
    input wire scs_pkg::scs_lbus_req_s i_lbus,
    input wire logic [15:0] i_delay,
    // answers
    output logic o_prog_done,
    output logic o_lbus_done,
    output logic [31:0] o_lbus_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt;
    logic busy;
    always @(posedge i_clk) begin
        o_prog_done <= 1'b0;
        if (!i_rst_n) begin
            busy <= 1'b0;
            cnt <= 16'h0;
        end else if (i_solve_start) begin
            busy <= 1'b1;
            cnt <= 16'h0;
        end else if (busy) begin
            // a slow answer is how an overrun is provoked
            cnt <= cnt + 16'h1;
            if (cnt == i_delay) begin
                busy <= 1'b0;
                o_prog_done <= 1'b1;
            end
        end
        // one wait cycle, then done; data only valid with done
        o_lbus_done <= i_rst_n & i_lbus.req & !o_lbus_done;
        o_lbus_rdata <= (i_lbus.req && !o_lbus_done) ? 32'h5a5a0001 : ~o_lbus_rdata;
    end
endmodule

// >>> bench/scs_top_tb.sv
// self-checking bench for the scan-cycle sequencer
module scs_top_tb;
    import scs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin err_total++; \
        $display("ERROR %s exp %h got %h", n, e, s); end end
    // ************************************************************
    // signals
    // ************************************************************
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    scs_apb_req_s apb = '0;
    scs_apb_rsp_s rsp;
    logic [31:0] fin = 32'h0;
    logic [31:0] fout, res = 32'h0, img, q, spd;
    logic done, sst, ldone, ival = 1'b0, run, fatal;
    logic [31:0] lrd;
    logic [15:0] dly = 16'h5;
    scs_lbus_req_s lbus;
    scs_phase_e ph;
    logic [7:0] due;
    int err_total = 0;
    int n_checks = 0;
    always #5 clk = ~clk;
    // ************************************************************
    // instances
    // ************************************************************
    scs_top #(.NPTS(32), .WDOG_CYC(32'h32)) dut (.I_CLOCK(clk), .I_RST_N(rst_n),
        .I_APB(apb), .O_APB(rsp), .I_FIELD_IN(fin), .O_FIELD_OUT(fout),
        .I_PROG_RESULT(res), .I_PROG_DONE(done), .I_IMM_OUT_VALID(ival),
        .I_IMM_OUT_PT(5'h3), .I_IMM_OUT_VAL(1'b1), .O_SOLVE_START(sst),
        .O_INPUT_IMAGE(img), .O_LBUS(lbus), .I_LBUS_DONE(ldone), .I_LBUS_RDATA(lrd),
        .O_SPEC_VALID(), .O_SPEC_DATA(spd), .O_LOOP_DUE(due), .O_PHASE(ph),
        .O_RUN(run), .O_FATAL(fatal));
    scs_partner prt (.i_clk(clk), .i_rst_n(rst_n), .i_solve_start(sst), .i_lbus(lbus),
        .i_delay(dly), .o_prog_done(done), .o_lbus_done(ldone), .o_lbus_rdata(lrd));
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic final_report();
        if (err_total == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk) apb <= {1'b1, 1'b0, w, a, d};
        @(posedge clk) apb.penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (rsp.pready === 1'b1) break;
        end
        if (i == 50) begin
            err_total++;
            final_report();
        end
        q = rsp.prdata;
        `CHK("pslverr", 1'b0, rsp.pslverr)
        apb <= '0;
    endtask
    task automatic wait_ph(input scs_phase_e p);
        int i;
        for (i = 0; i < 2000; i++) begin
            @(posedge clk);
            if (ph === p) break;
        end
        if (i == 2000) begin
            err_total++;
            final_report();
        end
    endtask
    task automatic scans(input int n);
        repeat (n) begin
            wait_ph(SCS_DIAG);
            wait_ph(SCS_IN_READ);
        end
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_prog_mode();
        bus(1'b0, REG_SCAN_MIN, 32'h0);
        `CHK("scan_min", SCAN_MIN_RESET, q)
        bus(1'b0, REG_WDOG, 32'h0);
        `CHK("wdog", 32'h32, q)
        fin <= 32'h0000a5a1;
        scans(3);
        `CHK("img_prog", 32'h0000a5a1, img)
        `CHK("out_prog", 32'h0, fout)
        bus(1'b0, 8'h7c, 32'h0);
        `CHK("unmapped", 32'h0, q)
    endtask
    task automatic t_run();
        int k;
        logic [7:0] d0;
        res <= 32'h0000c0f0;
        bus(1'b1, REG_LOOP_CFG, 32'h1);
        bus(1'b1, REG_LOOP_IVL, 32'h1);
        bus(1'b1, REG_CTRL, 32'h1);
        // phases must follow the fixed order
        for (k = 0; k < 9; k++) wait_ph(scs_phase_e'(k));
        scans(2);
        `CHK("run", 1'b1, run)
        `CHK("out_run", 32'h0000c0f0, fout)
        `CHK("spec_data", 32'h0000c0f0, spd)
        // immediate output reaches the pin inside the solve phase
        wait_ph(SCS_SOLVE);
        ival <= 1'b1;
        @(posedge clk) ival <= 1'b0;
        @(posedge clk);
        `CHK("imm_out", 32'h0000c0f8, fout)
        bus(1'b0, REG_SPECIAL, 32'h0);
        `CHK("lbus_rd", 32'h5a5a0001, q)
        bus(1'b1, REG_SPECIAL, 32'h1234abcd);
        @(posedge clk);
        `CHK("lbus_wr", 32'h1234abcd, lbus.wdata)
        // interval 1: a loop is due on every second scan only
        wait_ph(SCS_OUT_WRITE);
        d0 = due;
        wait_ph(SCS_OUT_WRITE);
        `CHK("loop_due", 8'h1, due | d0)
        `CHK("loop_ivl", 1'b1, due[0] ^ d0[0])
        bus(1'b0, REG_SCAN_MIN, 32'h0);
        `CHK("min_upd", 1'b1, q != SCAN_MIN_RESET)
    endtask
    task automatic t_override();
        fin <= 32'h0;
        scans(3);
        bus(1'b1, REG_OVERRIDE_X, 32'h4);
        bus(1'b1, REG_OVERRIDE_Y, 32'h1);
        fin <= 32'hffffffff;
        res <= 32'h0;
        bus(1'b1, REG_FORCE, 32'he0);
        // a second force before the peripheral phase would replace the first
        scans(1);
        bus(1'b1, REG_FORCE, 32'he1);
        scans(3);
        `CHK("ovr_x", 32'hfffffffb, img)
        `CHK("ovr_force", 32'h1, fout)
    endtask
    task automatic t_wdog();
        int i;
        bus(1'b1, REG_WDOG, 32'h40);
        bus(1'b0, REG_WDOG, 32'h0);
        `CHK("wdog_set", 32'h40, q)
        dly <= 16'h50;
        for (i = 0; i < 2000 && fatal !== 1'b1; i++) @(posedge clk);
        scans(1);
        `CHK("fatal", 1'b1, fatal)
        `CHK("run_off", 1'b0, run)
        `CHK("out_off", 32'h0, fout)
        bus(1'b0, REG_ERROR, 32'h0);
        `CHK("err_code", ERR_SW_TIMEOUT, q[15:0])
        bus(1'b1, REG_CTRL, 32'h1);
        bus(1'b0, REG_CTRL, 32'h0);
        `CHK("run_refused", 32'h2, q)
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_prog_mode();
        t_run();
        t_override();
        t_wdog();
        final_report();
    end
endmodule
